// ==== hdl/acpm_pkg.sv ====
// package for the alternate context priority map block
// assumes a single 20 MHz clock domain and an axi4-lite register bus
package acpm_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [3:0] CONFIG_OFFSET = 4'h0;
    localparam logic [3:0] PROGRAM_OFFSET = 4'h4;
    localparam logic [3:0] LOOKUP_OFFSET = 4'h8;
    localparam logic [3:0] RESULT_OFFSET = 4'hc;

    // ************************************************************
    // configuration word layout
    // ************************************************************
    localparam int WORD_WIDTH = 24;
    localparam int SETS = 4;
    localparam int SEL_WIDTH = 3;
    localparam int SET4_LSB = 12;
    localparam int SET3_LSB = 8;
    localparam int SET2_LSB = 4;
    localparam int SET1_LSB = 0;
    // erased word: every set unassigned, unimplemented bits high
    localparam logic [23:0] ERASED_VALUE = 24'hff_ffff;
    // ones in unimplemented positions: 23-15, 11, 7, 3
    localparam logic [23:0] UNIMPL_MASK = 24'hff_8888;
    localparam logic [2:0] SEL_UNASSIGNED = 3'h7;
    localparam logic [2:0] LEVEL_NONE = 3'h0;

    // ************************************************************
    // axi response codes
    // ************************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // result of one level lookup
    typedef struct packed {
        logic hit;
        logic [1:0] set_index;
    } acpm_lookup_s;

    typedef enum logic [1:0] {
        ACPM_W_IDLE,
        ACPM_W_RESP
    } acpm_wstate_e;

endpackage

// ==== hdl/acpm_decode.sv ====
// maps an interrupt priority level to the shadow set bound to it
// assumes a level of 0 never selects a shadow set
module acpm_decode (
    // configuration word
    input wire logic [23:0] config_word,
    // level asked for
    input wire logic [2:0] interrupt_priority_level,
    // lookup result
    output acpm_pkg::acpm_lookup_s result
);

    logic [3:0] match;

    // ************************************************************
    // per-set compare
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < acpm_pkg::SETS; g++) begin : g_set
            logic [2:0] sel;
            assign sel = config_word[g*4 +: 3];
            // code v means level v+1; 111 never matches a level
            assign match[g] = (sel != acpm_pkg::SEL_UNASSIGNED)
                && (interrupt_priority_level != acpm_pkg::LEVEL_NONE)
                && (sel == 3'(interrupt_priority_level - 3'h1));
        end
    endgenerate

    // lowest numbered set wins if software binds two sets to one level
    always_comb begin
        result = '0;
        for (int i = acpm_pkg::SETS - 1; i >= 0; i--) begin
            if (match[i]) begin
                result.hit = 1'b1;
                result.set_index = 2'(i);
            end
        end
    end

endmodule

// ==== hdl/acpm_top.sv ====
// alternate context priority map: program-once configuration word with lookup
// assumes an axi4-lite master issuing one read and one write at a time
module acpm_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read address
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // axi4-lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // cpu interrupt entry side
    input wire logic [2:0] interrupt_priority_level,
    output logic shadow_swap,
    output logic [1:0] shadow_set_index,
    // selector fields for the context switch logic
    output logic [2:0] shadow_set4_level_sel,
    output logic [2:0] shadow_set3_level_sel,
    output logic [2:0] shadow_set2_level_sel,
    output logic [2:0] shadow_set1_level_sel
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [23:0] cfg_r;
    logic [23:0] cfg_nxt;
    logic programmed_r;
    logic [2:0] probe_level_r;
    logic [1:0] bresp_r;
    logic bvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    logic rvalid_r;
    logic aw_held_r;
    logic [3:0] awaddr_r;
    logic w_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    acpm_pkg::acpm_wstate_e wstate_r;
    logic [23:0] cfg_view;
    logic [3:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic aw_have;
    logic w_have;
    logic wr_fire;
    logic wr_ok;
    acpm_pkg::acpm_lookup_s cpu_hit;
    acpm_pkg::acpm_lookup_s probe_hit;

    // unimplemented positions forced high on every view
    assign cfg_view = cfg_r | acpm_pkg::UNIMPL_MASK;

    // ************************************************************
    // field outputs
    // ************************************************************
    assign shadow_set4_level_sel = cfg_r[acpm_pkg::SET4_LSB +: acpm_pkg::SEL_WIDTH];
    assign shadow_set3_level_sel = cfg_r[acpm_pkg::SET3_LSB +: acpm_pkg::SEL_WIDTH];
    assign shadow_set2_level_sel = cfg_r[acpm_pkg::SET2_LSB +: acpm_pkg::SEL_WIDTH];
    assign shadow_set1_level_sel = cfg_r[acpm_pkg::SET1_LSB +: acpm_pkg::SEL_WIDTH];

    // ************************************************************
    // lookups
    // ************************************************************
    acpm_decode u_cpu_decode (
        .config_word(cfg_view),
        .interrupt_priority_level(interrupt_priority_level),
        .result(cpu_hit)
    );

    acpm_decode u_probe_decode (
        .config_word(cfg_view),
        .interrupt_priority_level(probe_level_r),
        .result(probe_hit)
    );

    // swap decision drives the context switch on interrupt entry
    assign shadow_swap = cpu_hit.hit;
    assign shadow_set_index = cpu_hit.set_index;

    // ************************************************************
    // write channel
    // ************************************************************
    assign aw_have = aw_held_r || s_axi_awvalid;
    assign w_have = w_held_r || s_axi_wvalid;
    assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
    assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
    assign wr_fire = (wstate_r == acpm_pkg::ACPM_W_IDLE) && aw_have && w_have;
    assign s_axi_awready = (wstate_r == acpm_pkg::ACPM_W_IDLE) && !aw_held_r;
    assign s_axi_wready = (wstate_r == acpm_pkg::ACPM_W_IDLE) && !w_held_r;
    assign wr_ok = (wr_addr == acpm_pkg::PROGRAM_OFFSET)
        || (wr_addr == acpm_pkg::LOOKUP_OFFSET);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            awaddr_r <= 4'h0;
        end else if (wr_fire) begin
            aw_held_r <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_r <= 1'b0;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else if (wr_fire) begin
            w_held_r <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate_r <= acpm_pkg::ACPM_W_IDLE;
            bvalid_r <= 1'b0;
            bresp_r <= acpm_pkg::RESP_OKAY;
        end else begin
            unique case (wstate_r)
                acpm_pkg::ACPM_W_IDLE: begin
                    if (wr_fire) begin
                        wstate_r <= acpm_pkg::ACPM_W_RESP;
                        bvalid_r <= 1'b1;
                        bresp_r <= wr_ok ? acpm_pkg::RESP_OKAY : acpm_pkg::RESP_SLVERR;
                    end
                end
                acpm_pkg::ACPM_W_RESP: begin
                    if (s_axi_bready) begin
                        wstate_r <= acpm_pkg::ACPM_W_IDLE;
                        bvalid_r <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // ************************************************************
    // program-once word
    // ************************************************************
    // programming can only clear bits, like erased otp cells; once only per reset
    always_comb begin
        cfg_nxt = cfg_r;
        for (int b = 0; b < 3; b++) begin
            if (wr_strb[b]) begin
                cfg_nxt[b*8 +: 8] = cfg_r[b*8 +: 8] & wr_data[b*8 +: 8];
            end
        end
        cfg_nxt = cfg_nxt | acpm_pkg::UNIMPL_MASK;
    end

    // reset stands in for an erase; a real part keeps the word across resets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= acpm_pkg::ERASED_VALUE;
            programmed_r <= 1'b0;
        end else if (wr_fire && (wr_addr == acpm_pkg::PROGRAM_OFFSET) && !programmed_r) begin
            cfg_r <= cfg_nxt;
            programmed_r <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            probe_level_r <= 3'h0;
        end else if (wr_fire && (wr_addr == acpm_pkg::LOOKUP_OFFSET) && wr_strb[0]) begin
            probe_level_r <= wr_data[2:0];
        end
    end

    // ************************************************************
    // read channel
    // ************************************************************
    assign s_axi_arready = !rvalid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= acpm_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= acpm_pkg::RESP_OKAY;
            unique case (s_axi_araddr)
                acpm_pkg::CONFIG_OFFSET: rdata_r <= {8'h00, cfg_view};
                acpm_pkg::PROGRAM_OFFSET: rdata_r <= {31'h0000_0000, programmed_r};
                acpm_pkg::LOOKUP_OFFSET: rdata_r <= {29'h0000_0000, probe_level_r};
                acpm_pkg::RESULT_OFFSET: rdata_r <= {29'h0000_0000, probe_hit};
                default: begin
                    rdata_r <= 32'h0000_0000;
                    rresp_r <= acpm_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

endmodule

// ==== verification/acpm_checker.sv ====
// port checker for the context priority map
// assumes one clock domain, synchronous active-low reset, bound to acpm_top
module acpm_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // read bus
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // lookup side
    input wire logic [2:0] interrupt_priority_level,
    input wire logic shadow_swap,
    input wire logic [1:0] shadow_set_index,
    input wire logic [2:0] shadow_set4_level_sel,
    input wire logic [2:0] shadow_set3_level_sel,
    input wire logic [2:0] shadow_set2_level_sel,
    input wire logic [2:0] shadow_set1_level_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************
    // assertions
    // ********************
    logic [2:0] sel [4];
    logic [3:0] lvl;
    assign sel[0] = shadow_set1_level_sel;
    assign sel[1] = shadow_set2_level_sel;
    assign sel[2] = shadow_set3_level_sel;
    assign sel[3] = shadow_set4_level_sel;
    // four bits wide, so code 111 maps to 8 and can never match a level
    assign lvl = {1'b0, interrupt_priority_level};
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_cfg_req; s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0; endsequence
    sequence s_cfg_ones;
        s_axi_rvalid && s_axi_rdata[23:15] == 9'h1ff
            && s_axi_rdata[11] && s_axi_rdata[7] && s_axi_rdata[3];
    endsequence
    property p_set1_hit;
        lvl == sel[0] + 4'h1 |-> shadow_swap && shadow_set_index == 2'h0;
    endproperty
    a_set1_hit: assert property (p_set1_hit) else $error("set one not selected");
    property p_set2_hit; lvl == sel[1] + 4'h1 |-> shadow_swap; endproperty
    a_set2_hit: assert property (p_set2_hit) else $error("set two level missed");
    property p_set3_hit; lvl == sel[2] + 4'h1 |-> shadow_swap; endproperty
    a_set3_hit: assert property (p_set3_hit) else $error("set three level missed");
    property p_set4_hit; lvl == sel[3] + 4'h1 |-> shadow_swap; endproperty
    a_set4_hit: assert property (p_set4_hit) else $error("set four level missed");
    property p_swap_cause; shadow_swap |-> lvl == sel[shadow_set_index] + 4'h1; endproperty
    a_swap_cause: assert property (p_swap_cause) else $error("swap without bound set");
    property p_erased; $rose(aresetn) |-> sel[0] == 3'h7 && sel[1] == 3'h7 && sel[2] == 3'h7
        && sel[3] == 3'h7 && !shadow_swap; endproperty
    a_erased: assert property (p_erased) else $error("word not erased after reset");
    property p_cfg_ones; s_cfg_req |=> s_cfg_ones; endproperty
    a_cfg_ones: assert property (p_cfg_ones) else $error("unimplemented bit read low");
    property p_cfg_fields; s_cfg_req |=> s_axi_rdata[14:12] == $past(sel[3])
        && s_axi_rdata[10:8] == $past(sel[2]) && s_axi_rdata[6:4] == $past(sel[1])
        && s_axi_rdata[2:0] == $past(sel[0]); endproperty
    a_cfg_fields: assert property (p_cfg_fields)
        else $error("field read differs");
    property p_read_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
endmodule

// ==== verification/acpm_cpu_model.sv ====
// interrupt entry model: presents a level and notes the set chosen
// assumes the bench asks for one entry at a time, 0 meaning no entry
module acpm_cpu_model (
    // clock
    input wire logic aclk,
    // entry request
    input wire logic [2:0] enter_level,
    // map side
    output logic [2:0] interrupt_priority_level,
    input wire logic shadow_swap,
    input wire logic [1:0] shadow_set_index,
    // last choice seen
    output logic swapped,
    output logic [1:0] used_set
);
    timeunit 1ns;
    timeprecision 1ps;
    initial interrupt_priority_level = 3'h0;
    always @(posedge aclk) begin
        interrupt_priority_level <= enter_level;
        swapped <= shadow_swap;
        used_set <= shadow_set_index;
    end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the context priority map
// assumes acpm_top with axi4-lite registers at 0x0, 0x4, 0x8 and 0xc
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic s_axi_wready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_wvalid = 1'b0;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b1;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b1;
    logic [2:0] interrupt_priority_level;
    logic [2:0] enter_level = 3'h0;
    logic shadow_swap;
    logic [1:0] shadow_set_index;
    logic [2:0] shadow_set4_level_sel;
    logic [2:0] shadow_set3_level_sel;
    logic [2:0] shadow_set2_level_sel;
    logic [2:0] shadow_set1_level_sel;
    logic swapped;
    logic [1:0] used_set;
    int n_mismatch = 0;
    int compares = 0;
    int cycles = 0;
    always #25 aclk = ~aclk;
    acpm_top u_acpm_top (.*);
    acpm_cpu_model u_acpm_cpu_model (.*);
    // ********************
    // helpers
    // ********************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // a negative pattern number stands for the erased word
    function automatic logic [2:0] code(input int c, input int s);
        return (c < 0) ? 3'h7 : 3'((c + s) % 7);
    endfunction
    function automatic logic [31:0] prog_word(input int c);
        logic [31:0] d;
        d = 32'h0000_0000;
        for (int s = 0; s < 4; s++) begin
            d[4*s +: 3] = code(c, s);
        end
        return d;
    endfunction
    task automatic do_reset();
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask
    // bready stays high, so the response is taken at the edge it is seen
    task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
            end
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
            end
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic probe_all(input int c);
        logic [2:0] e;
        logic [31:0] d;
        logic [1:0] r;
        for (int l = 0; l < 8; l++) begin
            e = 3'h0;
            for (int s = 3; s >= 0; s--) begin
                if ({1'b0, code(c, s)} + 4'h1 == 4'(l)) begin
                    e = {1'b1, 2'(s)};
                end
            end
            enter_level <= 3'(l);
            repeat (3) @(posedge aclk);
            check({swapped, used_set}, e, "entry swap");
            axi_write(4'h8, 32'(l), r);
            axi_read(4'hc, d, r);
            check(d, e, "result register");
        end
    endtask
    task automatic t_program(input int c);
        logic [31:0] d;
        logic [1:0] r;
        logic [11:0] sx;
        if (c >= 0) begin
            axi_write(4'h4, prog_word(c), r);
            check(r, acpm_pkg::RESP_OKAY, "program response");
        end
        axi_read(4'h0, d, r);
        check(d, prog_word(c) | 32'h00ff_8888, "config word");
        check(r, acpm_pkg::RESP_OKAY, "config read response");
        sx = {code(c, 3), code(c, 2), code(c, 1), code(c, 0)};
        check({shadow_set4_level_sel, shadow_set3_level_sel, shadow_set2_level_sel,
            shadow_set1_level_sel}, sx, "selects");
        probe_all(c);
    endtask
    task automatic t_refusals();
        logic [31:0] d;
        logic [1:0] r;
        axi_write(4'h0, 32'h0000_0000, r);
        check(r, acpm_pkg::RESP_SLVERR, "config write refused");
        axi_write(4'h4, 32'h0000_0000, r);
        check(r, acpm_pkg::RESP_OKAY, "second program response");
        axi_read(4'h0, d, r);
        check(d, prog_word(6) | 32'h00ff_8888, "word kept");
        axi_read(4'h4, d, r);
        check(d[0], 1'b1, "programmed flag");
        // last probe of the sweep left level 7 in the lookup register
        axi_read(4'h8, d, r);
        check(d, 32'h0000_0007, "probe level kept");
        axi_read(4'h2, d, r);
        check(r, acpm_pkg::RESP_SLVERR, "unmapped read refused");
        check(d, 32'h0000_0000, "unmapped read data");
    endtask
    initial begin
        do_reset();
        t_program(-1);
        for (int c = 0; c < 7; c++) begin
            do_reset();
            t_program(c);
        end
        t_refusals();
        give_verdict();
    end
    // whole run is under 1000 cycles
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
endmodule
bind acpm_top acpm_checker u_acpm_checker (.*);
